/* File: pkg/trc_pkg.sv */
package trc_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned TRC_CLK_NS   = 50;
  localparam int unsigned TRC_CONV_NS  = 1250000;
  localparam int unsigned TRC_CONV_CYC = TRC_CONV_NS / TRC_CLK_NS;
  localparam int unsigned TRC_TMR_W    = 15;
  localparam int unsigned TRC_CYC_W    = 25;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [11:0] TRC_IDX_CFG  = 12'h4b6;
  localparam logic [11:0] TRC_IDX_RSLT = 12'h4b7;
  localparam logic [11:0] TRC_IDX_STAT = 12'h4c0;
  localparam logic [11:0] TRC_IDX_MASK = 12'h4c1;
  localparam logic [15:0] TRC_ADDR_CFG  = {2'h0, TRC_IDX_CFG, 2'h0};
  localparam logic [15:0] TRC_ADDR_RSLT = {2'h0, TRC_IDX_RSLT, 2'h0};
  localparam logic [15:0] TRC_ADDR_STAT = {2'h0, TRC_IDX_STAT, 2'h0};
  localparam logic [15:0] TRC_ADDR_MASK = {2'h0, TRC_IDX_MASK, 2'h0};

  // ------------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------------
  localparam int unsigned TRC_CFG_SEL_LSB   = 0;
  localparam int unsigned TRC_CFG_EN_BIT    = 2;
  localparam int unsigned TRC_CFG_START_BIT = 3;
  localparam int unsigned TRC_STAT_DONE_BIT = 0;
  localparam int unsigned TRC_RSLT_W        = 12;
  localparam int unsigned TRC_ACC_W         = 22;
  localparam int unsigned TRC_CNT_W         = 11;
  localparam logic [1:0]  TRC_SEL_RST       = 2'h0;
  localparam logic        TRC_EN_RST        = 1'h0;
  localparam logic [11:0] TRC_RSLT_RST      = 12'h000;
  localparam logic        TRC_STAT_RST      = 1'h0;
  localparam logic        TRC_MASK_RST      = 1'h0;

  // ------------------------------------------------------------------
  // Averaging codes and their shifts
  // ------------------------------------------------------------------
  localparam logic [1:0] TRC_SEL_1    = 2'h0;
  localparam logic [1:0] TRC_SEL_256  = 2'h1;
  localparam logic [1:0] TRC_SEL_512  = 2'h2;
  localparam logic [1:0] TRC_SEL_1024 = 2'h3;
  localparam logic [3:0] TRC_SH_1     = 4'h0;
  localparam logic [3:0] TRC_SH_256   = 4'h8;
  localparam logic [3:0] TRC_SH_512   = 4'h9;
  localparam logic [3:0] TRC_SH_1024  = 4'ha;

  localparam logic [1:0] TRC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TRC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TRC_ST_IDLE = 2'b01,
    TRC_ST_RUN  = 2'b10
  } trc_state_type;

endpackage : trc_pkg

/* File: rtl/trc_temp_readout.sv */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
// Function
// - Writing one to the request bit, with the enable bit set and no reading running, starts a new temperature reading.
// - With one sample selected, result is ready 1.25 ms after a request; done flag is then set.
// - The request bit clears itself and always reads back zero.
// - Sensor enable bit, reset zero, switches the sensor on or off.
// - Averaging code selects 1, 256, 512 or 1024 samples.
// - Result interval is 1.25 ms times the selected sample count.
// - Result is a read-only 12-bit value, reset zero, upper bits zero.
module trc_temp_readout
  import trc_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = TRC_CONV_CYC
)
(
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic        ce_in,
  input  wire logic [11:0] temp_raw_in,
  input  wire logic [15:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [15:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic             irq_out
);

  // ------------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------------
  logic [15:0] awaddr_ff, nxt_awaddr;
  logic        aw_have_ff, nxt_aw_have;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0]  wstrb_ff, nxt_wstrb;
  logic        w_have_ff, nxt_w_have;
  logic        awready_ff, nxt_awready;
  logic        wready_ff, nxt_wready;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        arready_ff, nxt_arready;
  logic        rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic        wr_do;
  logic        rd_cfg_ff, nxt_rd_cfg;

  logic [1:0]           sel_ff;
  logic                 en_ff;
  logic [11:0]          result_ff;
  logic                 stat_ff;
  logic                 mask_ff;

  always_comb
  begin
    nxt_awaddr  = awaddr_ff;
    nxt_aw_have = aw_have_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_w_have  = w_have_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    nxt_rd_cfg  = rd_cfg_ff;
    if (s_axi_awvalid_in && awready_ff)
    begin
      nxt_awaddr  = s_axi_awaddr_in;
      nxt_aw_have = 1'b1;
    end
    if (s_axi_wvalid_in && wready_ff)
    begin
      nxt_wdata  = s_axi_wdata_in;
      nxt_wstrb  = s_axi_wstrb_in;
      nxt_w_have = 1'b1;
    end
    if (bvalid_ff && s_axi_bready_in)
      nxt_bvalid = 1'b0;
    wr_do = aw_have_ff && w_have_ff && !bvalid_ff;
    if (wr_do)
    begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_bvalid  = 1'b1;
      unique case (awaddr_ff)
        TRC_ADDR_CFG, TRC_ADDR_RSLT,
        TRC_ADDR_STAT, TRC_ADDR_MASK: nxt_bresp = TRC_RESP_OKAY;
        default:                      nxt_bresp = TRC_RESP_SLVERR;
      endcase
    end
    if (rvalid_ff && s_axi_rready_in)
      nxt_rvalid = 1'b0;
    if (s_axi_arvalid_in && arready_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = TRC_RESP_OKAY;
      nxt_rdata  = 32'h0;
      nxt_rd_cfg = (s_axi_araddr_in == TRC_ADDR_CFG);
      unique case (s_axi_araddr_in)
        TRC_ADDR_CFG:  nxt_rdata = {28'h0, 1'b0, en_ff, sel_ff};
        TRC_ADDR_RSLT: nxt_rdata = {20'h0, result_ff};
        TRC_ADDR_STAT: nxt_rdata = {31'h0, stat_ff};
        TRC_ADDR_MASK: nxt_rdata = {31'h0, mask_ff};
        default:       nxt_rresp = TRC_RESP_SLVERR;
      endcase
    end
    nxt_awready = !nxt_aw_have;
    nxt_wready  = !nxt_w_have;
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      awaddr_ff  <= 16'h0;
      aw_have_ff <= 1'b0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
      w_have_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= 2'h0;
      rd_cfg_ff  <= 1'b0;
    end
    else if (ce_in)
    begin
      awaddr_ff  <= nxt_awaddr;
      aw_have_ff <= nxt_aw_have;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      w_have_ff  <= nxt_w_have;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      rd_cfg_ff  <= nxt_rd_cfg;
    end
  end

  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out  = wready_ff;
  assign s_axi_bvalid_out  = bvalid_ff;
  assign s_axi_bresp_out   = bresp_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rvalid_out  = rvalid_ff;
  assign s_axi_rdata_out   = rdata_ff;
  assign s_axi_rresp_out   = rresp_ff;

  // ------------------------------------------------------------------
  // Conversion core
  // ------------------------------------------------------------------
  trc_state_type          state_ff, nxt_state;
  logic [1:0]             run_sel_ff, nxt_run_sel, nxt_sel;
  logic                   nxt_en, nxt_stat, nxt_mask, irq_ff, nxt_irq;
  logic [11:0]            nxt_result;
  logic [TRC_TMR_W-1:0]   tmr_ff, nxt_tmr;
  logic [TRC_CNT_W-1:0]   cnt_ff, nxt_cnt, need;
  logic [TRC_ACC_W-1:0]   acc_ff, nxt_acc, acc_sum;
  logic [3:0]             shift;
  logic                   start_req, done_evt, lo_we;

  always_comb
  begin
    nxt_sel     = sel_ff;
    nxt_en      = en_ff;
    nxt_mask    = mask_ff;
    nxt_stat    = stat_ff;
    nxt_result  = result_ff;
    nxt_state   = state_ff;
    nxt_run_sel = run_sel_ff;
    nxt_tmr     = tmr_ff;
    nxt_cnt     = cnt_ff;
    nxt_acc     = acc_ff;
    done_evt    = 1'b0;
    start_req   = 1'b0;
    lo_we       = wr_do && wstrb_ff[0];
    unique case (run_sel_ff)
      TRC_SEL_1:   shift = TRC_SH_1;
      TRC_SEL_256: shift = TRC_SH_256;
      TRC_SEL_512: shift = TRC_SH_512;
      TRC_SEL_1024: shift = TRC_SH_1024;
    endcase
    need    = TRC_CNT_W'(1) << shift;
    acc_sum = acc_ff + {10'h0, temp_raw_in};
    if (lo_we && awaddr_ff == TRC_ADDR_CFG)
    begin
      nxt_sel   = wdata_ff[TRC_CFG_SEL_LSB +: 2];
      nxt_en    = wdata_ff[TRC_CFG_EN_BIT];
      start_req = wdata_ff[TRC_CFG_START_BIT];
    end
    if (lo_we && awaddr_ff == TRC_ADDR_MASK)
      nxt_mask = wdata_ff[0];
    if (lo_we && awaddr_ff == TRC_ADDR_STAT && wdata_ff[0])
      nxt_stat = 1'b0;
    unique case (state_ff)
      TRC_ST_IDLE:
        if (start_req && nxt_en)
        begin
          nxt_state   = TRC_ST_RUN;
          nxt_run_sel = nxt_sel;
          nxt_tmr     = '0;
          nxt_cnt     = '0;
          nxt_acc     = '0;
        end
      TRC_ST_RUN:
        if (!nxt_en)
          nxt_state = TRC_ST_IDLE;
        else if (tmr_ff == TRC_TMR_W'(PERIOD_CYC - 1))
        begin
          nxt_tmr = '0;
          if (cnt_ff == need - TRC_CNT_W'(1))
          begin
            nxt_result = 12'(acc_sum >> shift);
            done_evt   = 1'b1;
            nxt_state  = TRC_ST_IDLE;
          end
          else
          begin
            nxt_cnt = cnt_ff + TRC_CNT_W'(1);
            nxt_acc = acc_sum;
          end
        end
        else
          nxt_tmr = tmr_ff + TRC_TMR_W'(1);
    endcase
    if (done_evt)
      nxt_stat = 1'b1;
    nxt_irq = nxt_stat && nxt_mask;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      sel_ff     <= TRC_SEL_RST;
      en_ff      <= TRC_EN_RST;
      mask_ff    <= TRC_MASK_RST;
      stat_ff    <= TRC_STAT_RST;
      result_ff  <= TRC_RSLT_RST;
      state_ff   <= TRC_ST_IDLE;
      run_sel_ff <= TRC_SEL_RST;
      tmr_ff     <= '0;
      cnt_ff     <= '0;
      acc_ff     <= '0;
      irq_ff     <= 1'b0;
    end
    else if (ce_in)
    begin
      sel_ff     <= nxt_sel;
      en_ff      <= nxt_en;
      mask_ff    <= nxt_mask;
      stat_ff    <= nxt_stat;
      result_ff  <= nxt_result;
      state_ff   <= nxt_state;
      run_sel_ff <= nxt_run_sel;
      tmr_ff     <= nxt_tmr;
      cnt_ff     <= nxt_cnt;
      acc_ff     <= nxt_acc;
      irq_ff     <= nxt_irq;
    end
  end

  assign irq_out = irq_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic [TRC_CYC_W-1:0] run_cyc_ff;

  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in || state_ff != TRC_ST_RUN)
      run_cyc_ff <= '0;
    else if (ce_in)
      run_cyc_ff <= run_cyc_ff + TRC_CYC_W'(1);
  end

  property p_start;
    @(posedge mclk_in) disable iff (!reset_n_in || !ce_in)
    (state_ff == TRC_ST_IDLE && start_req && nxt_en)
      |=> state_ff == TRC_ST_RUN;
  endproperty
  a_start: assert property (p_start)
    else $error("Request did not start a conversion.");

  property p_single_time;
    @(posedge mclk_in) disable iff (!reset_n_in || !ce_in)
    (done_evt && run_sel_ff == TRC_SEL_1)
      |-> run_cyc_ff == TRC_CYC_W'(PERIOD_CYC - 1) ##1 stat_ff;
  endproperty
  a_single_time: assert property (p_single_time)
    else $error("Single conversion time or done flag wrong.");

  property p_cfg_read;
    @(posedge mclk_in) disable iff (!reset_n_in || !ce_in)
    (rvalid_ff && rd_cfg_ff) |-> !rdata_ff[TRC_CFG_START_BIT];
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("Request bit read back as one.");

  property p_disable;
    @(posedge mclk_in) disable iff (!reset_n_in || !ce_in)
    !nxt_en |=> state_ff == TRC_ST_IDLE && !en_ff;
  endproperty
  a_disable: assert property (p_disable)
    else $error("Conversion runs with sensor disabled.");

  property p_count;
    @(posedge mclk_in) disable iff (!reset_n_in || !ce_in)
    done_evt |-> (run_sel_ff == TRC_SEL_256) == (cnt_ff == 11'd255)
      && (run_sel_ff == TRC_SEL_1024) == (cnt_ff == 11'd1023);
  endproperty
  a_count: assert property (p_count)
    else $error("Sample count does not match averaging code.");

  property p_interval;
    @(posedge mclk_in) disable iff (!reset_n_in || !ce_in)
    done_evt |-> run_cyc_ff == TRC_CYC_W'(PERIOD_CYC * need - 1);
  endproperty
  a_interval: assert property (p_interval)
    else $error("Result interval wrong.");

  property p_result;
    @(posedge mclk_in) disable iff (!reset_n_in || !ce_in)
    $changed(result_ff) |-> $past(done_evt) && stat_ff;
  endproperty
  a_result: assert property (p_result)
    else $error("Result changed without a finished conversion.");

  property p_done_full;
    @(posedge mclk_in) disable iff (!reset_n_in || !ce_in)
    $rose(stat_ff) |-> $past(cnt_ff) == $past(need) - 11'd1
      && state_ff == TRC_ST_IDLE;
  endproperty
  a_done_full: assert property (p_done_full)
    else $error("Done flag rose before the full set.");

  property p_irq;
    @(posedge mclk_in) disable iff (!reset_n_in || !ce_in)
    irq_ff == (stat_ff && mask_ff);
  endproperty
  a_irq: assert property (p_irq)
    else $error("Interrupt output disagrees with status and mask.");

  c_single: cover property (@(posedge mclk_in)
    done_evt && run_sel_ff == TRC_SEL_1);
  c_avg: cover property (@(posedge mclk_in)
    done_evt && run_sel_ff == TRC_SEL_256);
  c_irq: cover property (@(posedge mclk_in) $rose(irq_ff));
  c_slverr: cover property (@(posedge mclk_in)
    rvalid_ff && rresp_ff == TRC_RESP_SLVERR);

endmodule : trc_temp_readout

/* File: verif/trc_testbench.sv */
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin tests_run++; if ((got) !== (exp)) begin \
  mismatches++; $display("CHECK FAILED at %0t: %s", $time, msg); end end
module testbench;
  import trc_pkg::*;
  localparam int P = 8;
  logic        mclk;
  logic        rst_n;
  logic        ce;
  logic [11:0] raw;
  logic [15:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [15:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        irq;
  int          mismatches;
  int          tests_run;
  int          cycles;
  logic [31:0] d;
  logic [1:0]  r;

  trc_temp_readout #(.PERIOD_CYC(P)) dut (
    .mclk_in(mclk), .reset_n_in(rst_n), .ce_in(ce), .temp_raw_in(raw),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .irq_out(irq));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ------------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [31:0] v,
                    output logic [1:0] resp);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] v,
                    output logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    forever
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    v = rdata;
    resp = rresp;
  endtask : rd

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    rd(a, d, r);
    `CHK(d, e, "read value")
    `CHK(r, TRC_RESP_OKAY, "read response")
  endtask : rd_chk

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rd_chk(TRC_ADDR_CFG, 32'h0000_0000);
    rd_chk(TRC_ADDR_RSLT, 32'h0000_0000);
    rd_chk(TRC_ADDR_STAT, 32'h0000_0000);
    rd_chk(TRC_ADDR_MASK, 32'h0000_0000);
    `CHK(irq, 1'b0, "irq after reset")
    $display("test reset done");
  endtask : t_reset

  task automatic t_cfg();
    wr(TRC_ADDR_CFG, 32'h0000_fff3, r);
    `CHK(r, TRC_RESP_OKAY, "config write")
    rd_chk(TRC_ADDR_CFG, 32'h0000_0003);
    wr(TRC_ADDR_CFG, 32'h0000_0006, r);
    rd_chk(TRC_ADDR_CFG, 32'h0000_0006);
    wr(16'h0ff0, 32'h0000_0001, r);
    `CHK(r, TRC_RESP_SLVERR, "unmapped write")
    rd(16'h0ff0, d, r);
    `CHK(r, TRC_RESP_SLVERR, "unmapped read")
    `CHK(d, 32'h0000_0000, "unmapped data")
    $display("test config done");
  endtask : t_cfg

  task automatic t_conv(input logic [1:0] code, input logic [11:0] v);
    int n;
    int smp;
    smp = (code == 2'h0) ? 1 : (128 << code);
    raw <= v;
    wr(TRC_ADDR_MASK, 32'h0000_0001, r);
    wr(TRC_ADDR_CFG, {28'h0, 2'h3, code}, r);
    rd_chk(TRC_ADDR_CFG, {28'h0, 2'h1, code});
    n = 2;
    while (irq !== 1'b1)
    begin
      @(posedge mclk);
      n++;
    end
    `CHK(n >= P * smp - 2 && n <= P * smp + 3, 1'b1, "interval")
    rd_chk(TRC_ADDR_RSLT, {20'h0, v});
    rd_chk(TRC_ADDR_STAT, 32'h0000_0001);
    wr(TRC_ADDR_RSLT, 32'h0000_0abc, r);
    `CHK(r, TRC_RESP_OKAY, "result write")
    rd_chk(TRC_ADDR_RSLT, {20'h0, v});
    wr(TRC_ADDR_STAT, 32'h0000_0001, r);
    rd_chk(TRC_ADDR_STAT, 32'h0000_0000);
    `CHK(irq, 1'b0, "irq cleared")
    $display("test conversion code %0d done", code);
  endtask : t_conv

  task automatic t_mask();
    raw <= 12'h3c5;
    wr(TRC_ADDR_MASK, 32'h0000_0000, r);
    wr(TRC_ADDR_CFG, 32'h0000_000c, r);
    repeat (P + 8) @(posedge mclk);
    `CHK(irq, 1'b0, "masked irq")
    rd_chk(TRC_ADDR_STAT, 32'h0000_0001);
    rd_chk(TRC_ADDR_RSLT, 32'h0000_03c5);
    wr(TRC_ADDR_STAT, 32'h0000_0001, r);
    $display("test mask done");
  endtask : t_mask

  task automatic t_off();
    raw <= 12'h111;
    wr(TRC_ADDR_CFG, 32'h0000_0000, r);
    wr(TRC_ADDR_CFG, 32'h0000_0008, r);
    repeat (P + 8) @(posedge mclk);
    rd_chk(TRC_ADDR_STAT, 32'h0000_0000);
    rd_chk(TRC_ADDR_RSLT, 32'h0000_03c5);
    $display("test disabled done");
  endtask : t_off

  task automatic t_freeze();
    wr(TRC_ADDR_MASK, 32'h0000_0001, r);
    wr(TRC_ADDR_CFG, 32'h0000_000c, r);
    ce <= 1'b0;
    repeat (3 * P) @(posedge mclk);
    `CHK(irq, 1'b0, "frozen conversion")
    ce <= 1'b1;
    repeat (P + 4) @(posedge mclk);
    `CHK(irq, 1'b1, "conversion after freeze")
    rd_chk(TRC_ADDR_RSLT, 32'h0000_0111);
    wr(TRC_ADDR_STAT, 32'h0000_0001, r);
    $display("test clock enable done");
  endtask : t_freeze

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // ------------------------------------------------------------------
  // Timeout and main sequence
  // ------------------------------------------------------------------
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: timeout", $time);
      final_report();
    end
  end

  initial
  begin
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    raw = 12'h000;
    awaddr = 16'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = 16'h0;
    arvalid = 1'b0;
    rready = 1'b1;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset();
    t_cfg();
    t_conv(TRC_SEL_1, 12'h5a3);
    t_conv(TRC_SEL_256, 12'hfff);
    t_conv(TRC_SEL_512, 12'h001);
    t_conv(TRC_SEL_1024, 12'h800);
    t_mask();
    t_off();
    t_freeze();
    final_report();
  end
endmodule : testbench
